/* File: include/gate_ctrl_defines.svh */
// timing counts and reset values for the optical gate command block
`ifndef GATE_CTRL_DEFINES_SVH
`define GATE_CTRL_DEFINES_SVH
// Functional notes
// - channels independent, no dead time inserted
// - supply lockout darkens status, forces gate off
// - no gate commands forwarded during fault
// - command input positive logic, edge triggered
// - fixed separate turn-on and turn-off delays
// - status lit normally, dark on fault
// - each command edge gives delayed dark pulse
// - short circuit: gate off now, report later
// - fault released automatically after hold time
// - after fault, gate waits for next turn-on
// - indicator lit while primary supply sufficient
// ****************************************************************
// timing (cycles of the 40 ns clock)
// ****************************************************************
`define TURN_ON_DELAY_CYC 16'd25
`define TURN_OFF_DELAY_CYC 16'd25
`define ACK_START_DELAY_CYC 16'd25
`define ACK_DARK_WIDTH_CYC 16'd25
`define FAULT_REPORT_DELAY_CYC 16'd25
`define FAULT_HOLD_CYC 16'd2500
`define CNT_W 16
`define GATE_RESET_VAL 1'b0
`define STATUS_RESET_VAL 1'b0
// synchroniser reset: lockout bits start asserted so status cannot flash lit before the pins are seen
`define SYNC_RESET_VAL 7'h30
`endif

/* File: include/gate_ctrl_pkg.sv */
// types for the optical gate command block
package gate_ctrl_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_FAULT_WAIT, ST_FAULT_HOLD} chan_state_t;
   typedef logic [15:0] count_t;
endpackage

/* File: include/chan_if.sv */
// per-channel link between top and channel core
`timescale 1ns/1ps
interface chan_if;
   logic cmd_light;
   logic short_det;
   logic supply_low_lockout;
   logic gate_cmd;
   logic status_light;
   modport top (output cmd_light, output short_det, output supply_low_lockout, input gate_cmd, input status_light);
   modport core (input cmd_light, input short_det, input supply_low_lockout, output gate_cmd, output status_light);
endinterface

/* File: verilog/chan_core.sv */
// one channel: command edges, delays, acknowledge, fault handling
`timescale 1ns/1ps
`include "gate_ctrl_defines.svh"
module chan_core #(
   parameter logic [15:0] TURN_ON_DELAY = `TURN_ON_DELAY_CYC,
   parameter logic [15:0] TURN_OFF_DELAY = `TURN_OFF_DELAY_CYC,
   parameter logic [15:0] ACK_START_DELAY = `ACK_START_DELAY_CYC,
   parameter logic [15:0] ACK_DARK_WIDTH = `ACK_DARK_WIDTH_CYC,
   parameter logic [15:0] FAULT_REPORT_DELAY = `FAULT_REPORT_DELAY_CYC,
   parameter logic [15:0] FAULT_HOLD = `FAULT_HOLD_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   chan_if.core ch
);
   import gate_ctrl_pkg::*;
   // ****************************************************************
   // state
   // ****************************************************************
   chan_state_t st_q, st_d;
   logic cmd_prev_q, cmd_prev_d;
   logic gate_q, gate_d;
   logic pend_q, pend_d;
   logic pend_val_q, pend_val_d;
   count_t pend_cnt_q, pend_cnt_d;
   logic ack_wait_q, ack_wait_d;
   logic ack_dark_q, ack_dark_d;
   count_t ack_cnt_q, ack_cnt_d;
   count_t flt_cnt_q, flt_cnt_d;
   logic need_on_q, need_on_d;
   logic status_q, status_d;
   logic rise, fall, edge_seen, fault_now;

   assign rise = ch.cmd_light & ~cmd_prev_q;
   assign fall = ~ch.cmd_light & cmd_prev_q;
   assign edge_seen = rise | fall;
   assign fault_now = (st_q != ST_RUN) | ch.supply_low_lockout;

   always_comb begin
      st_d = st_q;
      cmd_prev_d = ch.cmd_light;
      gate_d = gate_q;
      pend_d = pend_q;
      pend_val_d = pend_val_q;
      pend_cnt_d = pend_cnt_q;
      ack_wait_d = ack_wait_q;
      ack_dark_d = ack_dark_q;
      ack_cnt_d = ack_cnt_q;
      flt_cnt_d = flt_cnt_q;
      need_on_d = need_on_q;
      // acknowledge pulse, restarted by each new edge
      if (edge_seen) begin
         ack_wait_d = 1'b1;
         ack_dark_d = 1'b0;
         ack_cnt_d = ACK_START_DELAY;
      end else if (ack_wait_q) begin
         if (ack_cnt_q <= 16'h0001) begin
            ack_wait_d = 1'b0;
            ack_dark_d = 1'b1;
            ack_cnt_d = ACK_DARK_WIDTH;
         end else begin
            ack_cnt_d = ack_cnt_q - 16'h0001;
         end
      end else if (ack_dark_q) begin
         if (ack_cnt_q <= 16'h0001) begin
            ack_dark_d = 1'b0;
         end else begin
            ack_cnt_d = ack_cnt_q - 16'h0001;
         end
      end
      // command path, delayed per direction
      if (fault_now) begin
         pend_d = 1'b0;
         gate_d = 1'b0;
      end else if (rise && need_on_q) begin
         need_on_d = 1'b0;
         pend_d = 1'b1;
         pend_val_d = 1'b1;
         pend_cnt_d = TURN_ON_DELAY;
      end else if (need_on_q) begin
         pend_d = 1'b0;
      end else if (edge_seen) begin
         pend_d = 1'b1;
         pend_val_d = rise;
         pend_cnt_d = rise ? TURN_ON_DELAY : TURN_OFF_DELAY;
      end else if (pend_q) begin
         if (pend_cnt_q <= 16'h0001) begin
            pend_d = 1'b0;
            gate_d = pend_val_q;
         end else begin
            pend_cnt_d = pend_cnt_q - 16'h0001;
         end
      end
      case (st_q)
         ST_RUN: begin
            if (ch.short_det) begin
               st_d = ST_FAULT_WAIT;
               gate_d = 1'b0;
               flt_cnt_d = FAULT_REPORT_DELAY;
            end
         end
         ST_FAULT_WAIT: begin
            if (flt_cnt_q <= 16'h0001) begin
               st_d = ST_FAULT_HOLD;
               flt_cnt_d = FAULT_HOLD;
            end else begin
               flt_cnt_d = flt_cnt_q - 16'h0001;
            end
         end
         ST_FAULT_HOLD: begin
            if (flt_cnt_q <= 16'h0001) begin
               st_d = ST_RUN;
               need_on_d = 1'b1;
            end else begin
               flt_cnt_d = flt_cnt_q - 16'h0001;
            end
         end
         default: st_d = ST_RUN;
      endcase
      if (ch.supply_low_lockout) begin
         need_on_d = 1'b1;
      end
      // lit unless locked out, in fault hold, or inside an acknowledge dark pulse
      status_d = ~ch.supply_low_lockout & (st_q != ST_FAULT_HOLD) & ~ack_dark_d;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_RUN;
         cmd_prev_q <= 1'b0;
         gate_q <= `GATE_RESET_VAL;
         pend_q <= 1'b0;
         pend_val_q <= 1'b0;
         pend_cnt_q <= 16'h0000;
         ack_wait_q <= 1'b0;
         ack_dark_q <= 1'b0;
         ack_cnt_q <= 16'h0000;
         flt_cnt_q <= 16'h0000;
         need_on_q <= 1'b1;
         status_q <= `STATUS_RESET_VAL;
      end else begin
         st_q <= st_d;
         cmd_prev_q <= cmd_prev_d;
         gate_q <= gate_d;
         pend_q <= pend_d;
         pend_val_q <= pend_val_d;
         pend_cnt_q <= pend_cnt_d;
         ack_wait_q <= ack_wait_d;
         ack_dark_q <= ack_dark_d;
         ack_cnt_q <= ack_cnt_d;
         flt_cnt_q <= flt_cnt_d;
         need_on_q <= need_on_d;
         status_q <= status_d;
      end
   end

   assign ch.gate_cmd = gate_q;
   assign ch.status_light = status_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_lockout_gate_off: assert property (@(posedge clk) disable iff (!arst_n)
      ch.supply_low_lockout |=> !gate_q && !status_q) else $error("gate or status on in lockout");
   a_fault_no_fwd: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q != ST_RUN) |=> !gate_q) else $error("gate on during fault");
   a_short_gate_off: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == ST_RUN && ch.short_det) |=> !gate_q && st_q == ST_FAULT_WAIT) else $error("short not handled");
   a_fault_dark: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == ST_FAULT_HOLD) |=> !status_q) else $error("status lit during fault hold");
   a_ack_start: assert property (@(posedge clk) disable iff (!arst_n)
      (ack_wait_q && ack_cnt_q == 16'h0001 && !edge_seen) |=> ack_dark_q && ack_cnt_q == ACK_DARK_WIDTH)
      else $error("ack pulse did not start");
   a_edge_arms_ack: assert property (@(posedge clk) disable iff (!arst_n)
      edge_seen |=> ack_wait_q && ack_cnt_q == ACK_START_DELAY) else $error("edge not acknowledged");
   a_release_wait_on: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == ST_FAULT_HOLD && flt_cnt_q == 16'h0001) |=> need_on_q && st_q == ST_RUN)
      else $error("fault release wrong");
   a_gate_needs_on: assert property (@(posedge clk) disable iff (!arst_n)
      (need_on_q && !gate_q) |=> !gate_q) else $error("gate resumed without turn-on");
   a_hold_len: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(st_q == ST_FAULT_HOLD) |-> flt_cnt_q == FAULT_HOLD) else $error("hold time wrong");
endmodule

/* File: verilog/optical_gate_command_status.sv */
// top: two independent channels, pin synchronisers, supply indicator
`timescale 1ns/1ps
`include "gate_ctrl_defines.svh"
module optical_gate_command_status #(
   parameter logic [15:0] TURN_ON_DELAY = `TURN_ON_DELAY_CYC,
   parameter logic [15:0] TURN_OFF_DELAY = `TURN_OFF_DELAY_CYC,
   parameter logic [15:0] ACK_START_DELAY = `ACK_START_DELAY_CYC,
   parameter logic [15:0] ACK_DARK_WIDTH = `ACK_DARK_WIDTH_CYC,
   parameter logic [15:0] FAULT_REPORT_DELAY = `FAULT_REPORT_DELAY_CYC,
   parameter logic [15:0] FAULT_HOLD = `FAULT_HOLD_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic command_light_in_ch1,
   input wire logic command_light_in_ch2,
   input wire logic short_det_ch1,
   input wire logic short_det_ch2,
   input wire logic supply_low_lockout_ch1,
   input wire logic supply_low_lockout_ch2,
   input wire logic primary_supply_ok,
   output logic gate_cmd_ch1,
   output logic gate_cmd_ch2,
   output logic status_light_out_ch1,
   output logic status_light_out_ch2,
   output logic supply_indicator
);
   import gate_ctrl_pkg::*;
   // ****************************************************************
   // two-flop synchronisers for all pin inputs
   // ****************************************************************
   logic [6:0] pins, s1_q, s2_q;
   logic ind_q;
   assign pins = {primary_supply_ok, supply_low_lockout_ch2, supply_low_lockout_ch1,
                  short_det_ch2, short_det_ch1, command_light_in_ch2, command_light_in_ch1};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= `SYNC_RESET_VAL;
         s2_q <= `SYNC_RESET_VAL;
         ind_q <= 1'b0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         ind_q <= s2_q[6];
      end
   end
   assign supply_indicator = ind_q;

   // ****************************************************************
   // channels, no cross coupling and no dead time
   // ****************************************************************
   chan_if c1();
   chan_if c2();
   assign c1.cmd_light = s2_q[0];
   assign c2.cmd_light = s2_q[1];
   assign c1.short_det = s2_q[2];
   assign c2.short_det = s2_q[3];
   assign c1.supply_low_lockout = s2_q[4];
   assign c2.supply_low_lockout = s2_q[5];
   chan_core #(.TURN_ON_DELAY(TURN_ON_DELAY), .TURN_OFF_DELAY(TURN_OFF_DELAY),
      .ACK_START_DELAY(ACK_START_DELAY), .ACK_DARK_WIDTH(ACK_DARK_WIDTH),
      .FAULT_REPORT_DELAY(FAULT_REPORT_DELAY), .FAULT_HOLD(FAULT_HOLD)) u_ch1 (
      .clk(clk),
      .arst_n(arst_n),
      .ch(c1.core)
   );
   chan_core #(.TURN_ON_DELAY(TURN_ON_DELAY), .TURN_OFF_DELAY(TURN_OFF_DELAY),
      .ACK_START_DELAY(ACK_START_DELAY), .ACK_DARK_WIDTH(ACK_DARK_WIDTH),
      .FAULT_REPORT_DELAY(FAULT_REPORT_DELAY), .FAULT_HOLD(FAULT_HOLD)) u_ch2 (
      .clk(clk),
      .arst_n(arst_n),
      .ch(c2.core)
   );
   assign gate_cmd_ch1 = c1.gate_cmd;
   assign gate_cmd_ch2 = c2.gate_cmd;
   assign status_light_out_ch1 = c1.status_light;
   assign status_light_out_ch2 = c2.status_light;

   a_indicator_follows: assert property (@(posedge clk) disable iff (!arst_n)
      s2_q[6] |=> supply_indicator) else $error("indicator not lit with supply");
endmodule

/* File: test/ctrl_model.sv */
// controller model: drives both optical command lights
`timescale 1ns/1ps
module ctrl_model (
   input wire logic clk,
   output logic cmd_ch1,
   output logic cmd_ch2
);
   localparam int DEAD_CYC = 2;
   initial begin
      cmd_ch1 = 1'b0;
      cmd_ch2 = 1'b0;
   end
   // the block inserts no dead time, so the other light goes dark first, then a gap
   task automatic set_cmd(input int ch, input logic v);
      @(negedge clk);
      if (v && ch == 0 && cmd_ch2) begin
         cmd_ch2 = 1'b0;
         repeat (DEAD_CYC) @(negedge clk);
      end
      if (v && ch != 0 && cmd_ch1) begin
         cmd_ch1 = 1'b0;
         repeat (DEAD_CYC) @(negedge clk);
      end
      if (ch == 0) begin
         cmd_ch1 = v;
      end else begin
         cmd_ch2 = v;
      end
   endtask
endmodule

/* File: test/optical_gate_command_status_tb.sv */
// self-checking bench for the optical gate command block
`timescale 1ns/1ps
module optical_gate_command_status_tb;
   localparam int TON = 6, TOFF = 10, AKD = 4, AKW = 5, FRD = 7, HLD = 40;
   logic clk = 1'b0, arst_n = 1'b0, sd1 = 1'b0, sd2 = 1'b0, uv1 = 1'b0, uv2 = 1'b0, pok = 1'b1;
   logic c1, c2, g1, g2, s1, s2, ind;
   int err_total = 0, samples_checked = 0, cyc = 0;
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   ctrl_model ctl (.clk(clk), .cmd_ch1(c1), .cmd_ch2(c2));
   optical_gate_command_status #(.TURN_ON_DELAY(16'(TON)), .TURN_OFF_DELAY(16'(TOFF)),
      .ACK_START_DELAY(16'(AKD)), .ACK_DARK_WIDTH(16'(AKW)), .FAULT_REPORT_DELAY(16'(FRD)),
      .FAULT_HOLD(16'(HLD))) DUT (.clk(clk), .arst_n(arst_n), .command_light_in_ch1(c1),
      .command_light_in_ch2(c2), .short_det_ch1(sd1), .short_det_ch2(sd2),
      .supply_low_lockout_ch1(uv1), .supply_low_lockout_ch2(uv2), .primary_supply_ok(pok),
      .gate_cmd_ch1(g1), .gate_cmd_ch2(g2), .status_light_out_ch1(s1), .status_light_out_ch2(s2),
      .supply_indicator(ind));
   task automatic end_sim();
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int n);
      samples_checked++;
      if (n < lo || n > hi) begin
         err_total++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, n);
      end
   endtask
   // k: 0 gate ch1, 1 gate ch2, 2 status ch1, 3 status ch2
   function automatic logic pick(input int k);
      case (k)
         0: return g1;
         1: return g2;
         2: return s1;
         default: return s2;
      endcase
   endfunction
   task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (pick(k) !== v && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   // command edge: gate moves after its own delay, status blinks dark meanwhile
   task automatic edge_cmd(input int ch, input logic v, input int dly);
      int ng, na, nw;
      ctl.set_cmd(ch, v);
      fork
         wait_lvl(ch, v, dly + 12, ng);
         begin
            wait_lvl(ch + 2, 1'b0, AKD + 12, na);
            wait_lvl(ch + 2, 1'b1, AKW + 4, nw);
         end
      join
      chk_rng("gate delay", dly, dly + 6, ng);
      chk_rng("ack start", AKD, AKD + 6, na);
      chk_rng("ack width", AKW, AKW + 1, nw);
      repeat (20) @(negedge clk);
   endtask
   task automatic t_reset();
      int n;
      wait_lvl(2, 1'b1, 10, n);
      // indicator has the same latency as the status, one flop after the synchroniser
      repeat (3) @(negedge clk);
      chk("status ch1 lit", 1'b1, s1);
      chk("status ch2 lit", 1'b1, s2);
      chk("gate ch1 off", 1'b0, g1);
      chk("indicator lit", 1'b1, ind);
      @(negedge clk) pok = 1'b0;
      repeat (6) @(negedge clk);
      chk("indicator dark", 1'b0, ind);
      @(negedge clk) pok = 1'b1;
      repeat (6) @(negedge clk);
      chk("indicator relit", 1'b1, ind);
   endtask
   task automatic t_switch();
      edge_cmd(0, 1'b1, TON);
      chk("gate ch2 idle", 1'b0, g2);
      chk("status ch2 untouched", 1'b1, s2);
      edge_cmd(0, 1'b0, TOFF);
   endtask
   task automatic t_short();
      int n, t0;
      edge_cmd(0, 1'b1, TON);
      @(negedge clk) sd1 = 1'b1;
      t0 = cyc;
      wait_lvl(0, 1'b0, 6, n);
      chk_rng("short gate off", 0, 4, n);
      wait_lvl(2, 1'b0, FRD + 8, n);
      chk_rng("fault report", FRD, FRD + 6, cyc - t0);
      @(negedge clk) sd1 = 1'b0;
      ctl.set_cmd(0, 1'b0);
      repeat (8) @(posedge clk);
      ctl.set_cmd(0, 1'b1);
      repeat (TON + 10) @(negedge clk);
      chk("gate held in fault", 1'b0, g1);
      chk("status dark in fault", 1'b0, s1);
      wait_lvl(2, 1'b1, HLD + FRD + 20, n);
      chk_rng("fault release", HLD, HLD + FRD + 12, cyc - t0);
      repeat (TON + 10) @(negedge clk);
      chk("gate waits for turn-on", 1'b0, g1);
      ctl.set_cmd(0, 1'b0);
      repeat (20) @(posedge clk);
      edge_cmd(0, 1'b1, TON);
      edge_cmd(0, 1'b0, TOFF);
   endtask
   task automatic t_lockout();
      int n;
      edge_cmd(1, 1'b1, TON);
      @(negedge clk) uv2 = 1'b1;
      wait_lvl(1, 1'b0, 8, n);
      chk_rng("lockout gate off", 0, 6, n);
      wait_lvl(3, 1'b0, 8, n);
      chk_rng("lockout status dark", 0, 6, n);
      chk("other channel lit", 1'b1, s1);
      @(negedge clk) uv2 = 1'b0;
      wait_lvl(3, 1'b1, 10, n);
      chk("lockout cleared", 1'b1, s2);
      chk("gate stays off", 1'b0, g2);
      ctl.set_cmd(1, 1'b0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      t_reset();
      t_switch();
      t_short();
      t_lockout();
      end_sim();
   end
   // whole run is well under 1000 cycles
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
endmodule
